// file: verilog/pmic_regs_pkg.sv
// Package for the step-down flag, mask, status and linear-regulator config registers.
// Assumes an I2C engine outside that turns bus transactions into register-port strobes.
package pmic_regs_pkg;

    localparam logic [7:0] ADDR_FAIL_FLAGS  = 8'h07;
    localparam logic [7:0] ADDR_FAIL_MASK   = 8'h0F;
    localparam logic [7:0] ADDR_POWER_GOOD  = 8'h14;
    localparam logic [7:0] ADDR_LDO0_CONFIG = 8'h23;
    localparam logic [7:0] ADDR_LDO1_CONFIG = 8'h25;

    localparam logic [7:0] RESET_FAIL_FLAGS = 8'h00;
    localparam logic [7:0] RESET_FAIL_MASK  = 8'hFF;
    localparam logic [7:0] RESET_POWER_GOOD = 8'hFF;
    localparam logic [3:0] STATUS_LOW_BITS  = 4'hF;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // Config reset pattern 01xx_00x0; x bits come from one-time-programmable settings
    localparam logic [7:0] RESET_LDO_FIXED  = 8'h40;
    localparam logic [7:0] LDO_OTP_BIT_MASK = 8'h32;

    localparam int         BUCK_COUNT       = 4;
    localparam int         LDO_COUNT        = 2;
    localparam int         SEQ_COUNT        = 3;
    localparam int         FAIL_FIELD_LSB   = 4;
    localparam int         MODE_FIELD_LSB   = 6;

    localparam logic [1:0] MODE_OFF_OR_SEQ  = 2'b00;
    localparam logic [1:0] MODE_GROUP_LP    = 2'b01;
    localparam logic [1:0] MODE_LOW_POWER   = 2'b10;
    localparam logic [1:0] MODE_NORMAL      = 2'b11;
    localparam logic [1:0] SOURCE_REGISTER  = 2'b11;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic enable;
        logic low_power;
    } ldo_ctrl_t;

endpackage : pmic_regs_pkg

// file: verilog/buck_irq_status_ldo_mode_regs.sv
// Flag, mask and status registers for four bucks, plus two linear-regulator config registers.
// Assumes register strobes, comparator outputs and sequencer states synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module buck_irq_status_ldo_mode_regs #(
    parameter logic [7:0] LDO0_OTP_BITS = 8'h00,
    parameter logic [7:0] LDO1_OTP_BITS = 8'h00
) (
    input  wire logic                                            clk_sys,
    input  wire logic                                            rst_n,
    input  wire logic                                            global_shutdown,
    input  wire pmic_regs_pkg::reg_req_t                         reg_req,
    output logic [7:0]                                           reg_rdata,
    input  wire logic [pmic_regs_pkg::BUCK_COUNT-1:0]            buck_not_power_good,
    input  wire logic [pmic_regs_pkg::LDO_COUNT-1:0][1:0]        linear_reg_sequencer_source,
    input  wire logic [pmic_regs_pkg::SEQ_COUNT-1:0]             sequencer_enabled,
    input  wire logic                                            global_low_power,
    output pmic_regs_pkg::ldo_ctrl_t [pmic_regs_pkg::LDO_COUNT-1:0] ldo_ctrl,
    output logic                                                 interrupt_out_n
);
    import pmic_regs_pkg::*;

    logic [7:0]            buck_power_fail_flags;
    logic [7:0]            buck_power_fail_mask;
    logic [BUCK_COUNT-1:0] prev_not_good;
    logic [BUCK_COUNT-1:0] fail_event;
    logic [7:0]            linear_reg_config [LDO_COUNT];
    logic [7:0]            ldo_reset [LDO_COUNT];
    logic                  read_flags;

    assign ldo_reset[0] = RESET_LDO_FIXED | (LDO0_OTP_BITS & LDO_OTP_BIT_MASK);
    assign ldo_reset[1] = RESET_LDO_FIXED | (LDO1_OTP_BITS & LDO_OTP_BIT_MASK);

    function automatic ldo_ctrl_t decode_mode(input logic [1:0] mode,
                                              input logic [1:0] source,
                                              input logic [SEQ_COUNT-1:0] seq_on,
                                              input logic glp);
        ldo_ctrl_t c;
        logic      on;
        c  = '{enable: 1'b0, low_power: 1'b0};
        on = 1'b0;
        if (source == SOURCE_REGISTER) begin
            case (mode)
                MODE_OFF_OR_SEQ: c = '{enable: 1'b0, low_power: 1'b0};
                MODE_GROUP_LP:   c = '{enable: 1'b1, low_power: glp};
                MODE_LOW_POWER:  c = '{enable: 1'b1, low_power: 1'b1};
                MODE_NORMAL:     c = '{enable: 1'b1, low_power: 1'b0};
                default:         c = '{enable: 1'b0, low_power: 1'b0};
            endcase
        end else begin
            on = seq_on[source];
            case (mode)
                MODE_OFF_OR_SEQ: c = '{enable: on, low_power: 1'b0};
                MODE_GROUP_LP:   c = '{enable: on, low_power: on & glp};
                MODE_LOW_POWER:  c = '{enable: on, low_power: on};
                MODE_NORMAL:     c = '{enable: on, low_power: 1'b0};
                default:         c = '{enable: 1'b0, low_power: 1'b0};
            endcase
        end
        return c;
    endfunction : decode_mode

    ////////////////////////////////////////////////////////////////////////////////
    // Power-fail flags

    // Drop below threshold shows as not-good going from 0 to 1
    assign fail_event = buck_not_power_good & ~prev_not_good;
    assign read_flags = reg_req.rd && (reg_req.addr == ADDR_FAIL_FLAGS);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_not_good <= '0;
        end else begin
            prev_not_good <= buck_not_power_good;
        end
    end

    // A drop landing in the read cycle survives: set wins over clear-on-read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buck_power_fail_flags <= RESET_FAIL_FLAGS;
        end else if (global_shutdown) begin
            buck_power_fail_flags <= RESET_FAIL_FLAGS;
        end else begin
            buck_power_fail_flags[7:FAIL_FIELD_LSB] <=
                (read_flags ? 4'h0 : buck_power_fail_flags[7:FAIL_FIELD_LSB])
                | {fail_event[0], fail_event[1], fail_event[2], fail_event[3]};
            buck_power_fail_flags[FAIL_FIELD_LSB-1:0] <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mask and configuration registers

    // Low mask nibble is stored as written; host keeps it at ones
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buck_power_fail_mask <= RESET_FAIL_MASK;
        end else if (global_shutdown) begin
            buck_power_fail_mask <= RESET_FAIL_MASK;
        end else if (reg_req.wr && reg_req.addr == ADDR_FAIL_MASK) begin
            buck_power_fail_mask <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            linear_reg_config[0] <= RESET_LDO_FIXED | (LDO0_OTP_BITS & LDO_OTP_BIT_MASK);
            linear_reg_config[1] <= RESET_LDO_FIXED | (LDO1_OTP_BITS & LDO_OTP_BIT_MASK);
        end else if (global_shutdown) begin
            linear_reg_config[0] <= ldo_reset[0];
            linear_reg_config[1] <= ldo_reset[1];
        end else if (reg_req.wr && reg_req.addr == ADDR_LDO0_CONFIG) begin
            linear_reg_config[0] <= reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == ADDR_LDO1_CONFIG) begin
            linear_reg_config[1] <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, regulator control, interrupt

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_FAIL_FLAGS:  reg_rdata <= buck_power_fail_flags;
                ADDR_FAIL_MASK:   reg_rdata <= buck_power_fail_mask;
                ADDR_POWER_GOOD:  reg_rdata <= {buck_not_power_good[0], buck_not_power_good[1],
                                                buck_not_power_good[2], buck_not_power_good[3],
                                                STATUS_LOW_BITS};
                ADDR_LDO0_CONFIG: reg_rdata <= linear_reg_config[0];
                ADDR_LDO1_CONFIG: reg_rdata <= linear_reg_config[1];
                default:          reg_rdata <= UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ldo_ctrl <= '0;
        end else begin
            for (int i = 0; i < LDO_COUNT; i++) begin
                ldo_ctrl[i] <= decode_mode(linear_reg_config[i][7:MODE_FIELD_LSB],
                                           linear_reg_sequencer_source[i],
                                           sequencer_enabled, global_low_power);
            end
        end
    end

    // Registered so the pin never glitches while flags and mask change together
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~|(buck_power_fail_flags[7:FAIL_FIELD_LSB]
                                  & ~buck_power_fail_mask[7:FAIL_FIELD_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_flag_read_quiet;
        read_flags && !global_shutdown && fail_event == '0;
    endsequence

    sequence s_flags_empty;
        buck_power_fail_flags == 8'h00;
    endsequence

    property p_read_clears;
        @(posedge clk_sys) disable iff (!rst_n) s_flag_read_quiet |=> s_flags_empty;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flags not cleared by read");

    property p_buck0_flag;
        @(posedge clk_sys) disable iff (!rst_n)
            (fail_event[0] && !global_shutdown) |=> buck_power_fail_flags[7];
    endproperty
    a_buck0_flag: assert property (p_buck0_flag) else $error("buck 0 drop not flagged");

    property p_other_flags;
        @(posedge clk_sys) disable iff (!rst_n)
            (!global_shutdown && fail_event[3:1] != 3'h0) |=>
            ((buck_power_fail_flags[6:4] & $past({fail_event[1], fail_event[2], fail_event[3]}))
             == $past({fail_event[1], fail_event[2], fail_event[3]}));
    endproperty
    a_other_flags: assert property (p_other_flags)
        else $error("buck 1-3 drop not flagged");

    property p_mask_write;
        @(posedge clk_sys) disable iff (!rst_n)
            (reg_req.wr && reg_req.addr == ADDR_FAIL_MASK && !global_shutdown)
            |=> buck_power_fail_mask == $past(reg_req.wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_status_read;
        @(posedge clk_sys) disable iff (!rst_n)
            (reg_req.rd && reg_req.addr == ADDR_POWER_GOOD)
            |=> reg_rdata[7:4] == $past({buck_not_power_good[0], buck_not_power_good[1],
                                         buck_not_power_good[2], buck_not_power_good[3]})
                && reg_rdata[3:0] == 4'hF;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // Host spaces its strobes, so write and readback are checked as two steps
    property p_config_write;
        @(posedge clk_sys) disable iff (!rst_n)
            (reg_req.wr && reg_req.addr == ADDR_LDO0_CONFIG && !global_shutdown)
            |=> linear_reg_config[0] == $past(reg_req.wdata);
    endproperty
    a_config_write: assert property (p_config_write) else $error("config write lost");

    property p_config_read;
        @(posedge clk_sys) disable iff (!rst_n)
            (reg_req.rd && reg_req.addr == ADDR_LDO0_CONFIG)
            |=> reg_rdata == $past(linear_reg_config[0]);
    endproperty
    a_config_read: assert property (p_config_read) else $error("config readback wrong");

    property p_reg_off;
        @(posedge clk_sys) disable iff (!rst_n)
            (linear_reg_sequencer_source[0] == 2'b11 && linear_reg_config[0][7:6] == 2'b00)
            |=> !ldo_ctrl[0].enable;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator not off");

    property p_reg_forced_lp;
        @(posedge clk_sys) disable iff (!rst_n)
            (linear_reg_sequencer_source[0] == 2'b11 && linear_reg_config[0][7:6] == 2'b10)
            |=> ldo_ctrl[0].enable && ldo_ctrl[0].low_power;
    endproperty
    a_reg_forced_lp: assert property (p_reg_forced_lp)
        else $error("not forced low power");

    property p_seq_off;
        @(posedge clk_sys) disable iff (!rst_n)
            (linear_reg_sequencer_source[1] != 2'b11
             && !sequencer_enabled[linear_reg_sequencer_source[1]])
            |=> !ldo_ctrl[1].enable;
    endproperty
    a_seq_off: assert property (p_seq_off) else $error("on with sequencer off");

    property p_irq_out;
        @(posedge clk_sys) disable iff (!rst_n)
            (|(buck_power_fail_flags[7:4] & ~buck_power_fail_mask[7:4])) |=> !interrupt_out_n;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt not asserted");

endmodule : buck_irq_status_ldo_mode_regs

`default_nettype wire

// file: bench/host_model.sv
// Host processor model: issues single-byte register strobes like the I2C engine would.
// Assumes rd/wr are sampled on rising clk_sys and read data is ready the edge after.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import pmic_regs_pkg::*;
(
    input  wire logic             clk_sys,
    output var  pmic_regs_pkg::reg_req_t reg_req,
    input  wire logic [7:0]       reg_rdata
);
    initial reg_req = '0;

    task automatic write_reg(input logic [7:0] a, input logic [7:0] data);
        logic [7:0] w;
        w = (a == ADDR_FAIL_MASK) ? (data | 8'h0F) : data;
        @(negedge clk_sys);
        reg_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(negedge clk_sys);
        // Released bus shows garbage, not the last value
        reg_req <= '{addr: ~a, wdata: ~w, wr: 1'b0, rd: 1'b0};
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] data);
        @(negedge clk_sys);
        reg_req <= '{addr: a, wdata: ~a, wr: 1'b0, rd: 1'b1};
        @(negedge clk_sys);
        data = reg_rdata;
        reg_req <= '{addr: ~a, wdata: a, wr: 1'b0, rd: 1'b0};
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the buck flag/mask/status and linear-regulator mode registers.
// Assumes host_model drives the register port; all other inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pmic_regs_pkg::*;
    localparam logic [7:0] OTP0 = 8'hFF;
    localparam logic [7:0] OTP1 = 8'h00;
    logic                 clk_sys = 1'b0;
    logic                 rst_n;
    logic                 global_shutdown;
    reg_req_t             reg_req;
    logic [7:0]           reg_rdata;
    logic [3:0]           ng;
    logic [1:0][1:0]      src;
    logic [2:0]           seq_en;
    logic                 glp;
    ldo_ctrl_t [1:0]      ldo_ctrl;
    logic                 irq_n;
    int                   err_count = 0;
    int                   checks = 0;
    int                   seed;
    int                   m_flags;
    int                   m_mask;
    logic [7:0]           cfg [2];
    logic [31:0]          wd;
    logic [1:0]           c;

    always #2 clk_sys = ~clk_sys;

    buck_irq_status_ldo_mode_regs #(.LDO0_OTP_BITS(OTP0), .LDO1_OTP_BITS(OTP1)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .global_shutdown(global_shutdown),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .buck_not_power_good(ng),
        .linear_reg_sequencer_source(src), .sequencer_enabled(seq_en),
        .global_low_power(glp), .ldo_ctrl(ldo_ctrl), .interrupt_out_n(irq_n));
    host_model u_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.read_reg(a, v);
        check(v, e);
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(negedge clk_sys);
    endtask : settle

    task automatic finish_test();
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic defaults_chk();
        rd_chk(ADDR_FAIL_FLAGS, 8'h00);
        rd_chk(ADDR_FAIL_MASK, 8'hFF);
        rd_chk(ADDR_LDO0_CONFIG, 8'h40 | (OTP0 & 8'h32));
        rd_chk(ADDR_LDO1_CONFIG, 8'h40 | (OTP1 & 8'h32));
        m_mask = 8'hFF;
        cfg[0] = 8'h40 | (OTP0 & 8'h32);
        cfg[1] = 8'h40 | (OTP1 & 8'h32);
    endtask : defaults_chk

    initial begin
        #100000;
        err_count++;
        finish_test();
    end

    initial begin
        seed = 32'hCDC3;
        rst_n = 1'b0;
        global_shutdown = 1'b0;
        ng = 4'h0;
        src = '0;
        seq_en = 3'h0;
        glp = 1'b0;
        m_flags = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        defaults_chk();
        rd_chk(ADDR_POWER_GOOD, 8'h0F);
        rd_chk(8'h30, 8'h00);
        // One buck drops at a time, mask changed at random before each drop
        for (int i = 0; i < 4; i++) begin
            wd = $random(seed);
            m_mask = wd[7:0] | 8'h0F;
            u_host.write_reg(ADDR_FAIL_MASK, wd[7:0]);
            rd_chk(ADDR_FAIL_MASK, m_mask[7:0]);
            @(negedge clk_sys) ng[i] = 1'b1;
            m_flags = m_flags | (8'h80 >> i);
            settle();
            check({7'h0, irq_n}, {7'h0, (m_flags & ~m_mask & 8'hF0) == 0});
            rd_chk(ADDR_POWER_GOOD, {ng[0], ng[1], ng[2], ng[3], 4'hF});
            rd_chk(ADDR_FAIL_FLAGS, m_flags[7:0]);
            m_flags = 0;
            rd_chk(ADDR_FAIL_FLAGS, 8'h00);
            check({7'h0, irq_n}, 8'h01);
        end
        u_host.write_reg(ADDR_FAIL_FLAGS, 8'hF0);
        u_host.write_reg(ADDR_POWER_GOOD, 8'h00);
        rd_chk(ADDR_FAIL_FLAGS, 8'h00);
        rd_chk(ADDR_POWER_GOOD, 8'hFF);
        @(negedge clk_sys) ng = 4'h0;
        for (int k = 0; k < 64; k++) begin
            wd = $random(seed);
            cfg[0] = {k[1:0], wd[5:0]};
            cfg[1] = {wd[13:12], wd[21:16]};
            u_host.write_reg(ADDR_LDO0_CONFIG, cfg[0]);
            u_host.write_reg(ADDR_LDO1_CONFIG, cfg[1]);
            @(negedge clk_sys);
            src[0] = k[3:2];
            src[1] = wd[7:6];
            seq_en = wd[10:8];
            glp = wd[11];
            settle();
            for (int j = 0; j < 2; j++) begin
                c[0] = (cfg[j][7:6] == 2'b10) || (cfg[j][7:6] == 2'b01 && glp);
                c[1] = (src[j] == SOURCE_REGISTER) ? (cfg[j][7:6] != 2'b00) : seq_en[src[j]];
                check({7'h0, ldo_ctrl[j].enable}, {7'h0, c[1]});
                if (c[1]) begin
                    check({7'h0, ldo_ctrl[j].low_power}, {7'h0, c[0]});
                end
            end
            rd_chk(ADDR_LDO0_CONFIG, cfg[0]);
            rd_chk(ADDR_LDO1_CONFIG, cfg[1]);
        end
        // Shutdown with a pending flag and non-default mask and configs
        u_host.write_reg(ADDR_FAIL_MASK, 8'h00);
        @(negedge clk_sys) ng[2] = 1'b1;
        settle();
        check({7'h0, irq_n}, 8'h00);
        @(negedge clk_sys) global_shutdown = 1'b1;
        @(negedge clk_sys) global_shutdown = 1'b0;
        settle();
        check({7'h0, irq_n}, 8'h01);
        defaults_chk();
        finish_test();
    end
endmodule : tb
`default_nettype wire
